/* File: bench/config_word_and_checksum_bench.sv */
// bench: decode table, checksum runs, reset and refusal cases
`timescale 1ns/1ps
`default_nettype none
module config_word_and_checksum_bench;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [13:0] cfg;
    logic [10:0] dec;
    logic [31:0] rng;
  } cwc_row_s;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic req;
  logic [13:0] maddr;
  logic ack;
  logic [13:0] mdata;
  logic [13:0] cfg = 14'h3FFF;
  logic [6:0] ctl = 7'h00;
  logic slow = 1'b0;
  int n_errors = 0;
  int n_tests = 0;
  cwc_row_s rows [11];
  logic [35:0] rv [10];
  // ---------------
  // clock and parts
  // ---------------
  always #12.5 clk_sys_in = ~clk_sys_in;
  cwc_top dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .mem_req_out(req), .mem_addr_out(maddr),
    .mem_ack_in(ack), .mem_data_in(mdata)
  );
  cwc_dev_model dev (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mem_req_in(req), .mem_addr_in(maddr),
    .cfg_word_in(cfg), .layout_b_in(ctl[3]), .small_in(ctl[4]), .slow_in(slow),
    .mem_ack_out(ack), .mem_data_out(mdata)
  );
  // -------
  // helpers
  // -------
  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic av(input logic r, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    rd <= r;
    wr <= ~r;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      results();
    end
  endtask
  function automatic logic [13:0] vw();
    return cfg | (ctl[3] ? 14'h3F80 : 14'h00C0);
  endfunction
  // expected sum from the memory image the model holds
  function automatic logic [15:0] esum(input logic [13:0] last, input logic [13:0] pl,
                                       input logic [31:0] mo, input logic [15:0] cst);
    logic [15:0] s;
    logic [13:0] w;
    s = 16'h0000;
    for (int a = 0; a <= int'(last); a++) begin
      w = 14'(a) ^ 14'h25E6;
      if (a < int'(pl)) s = s + {2'b00, w};
      else if (ctl[2]) s = s + {9'h0, ~(w[13:7] ^ w[6:0])};
    end
    s = s + {2'b00, (vw() & mo[13:0]) | mo[29:16]};
    if (ctl[1]) s = s + 16'h2746;
    return s + cst;
  endfunction
  task automatic run(input logic [6:0] c, input logic [13:0] cw, input logic [13:0] last,
                     input logic [13:0] pl, input logic [31:0] mo, input logic [15:0] cst,
                     input logic poke);
    logic [31:0] q;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    ctl <= c;
    cfg <= cw;
    av(0, 4'h2, {18'h0, last}, q);
    av(0, 4'h3, {18'h0, pl}, q);
    av(0, 4'h4, mo, q);
    av(0, 4'h5, {16'h0, cst}, q);
    av(0, 4'h0, {25'h0, c | 7'h01}, q);
    if (poke) av(0, 4'h2, 32'h0000_0123, q);
    do begin
      av(1, 4'h1, 0, q);
      n++;
    end while (q[1] !== 1'b1 && n < 500);
    if (n >= 500) begin
      n_errors++;
      results();
    end
    av(1, 4'h6, 0, q);
    chk(q, {16'h0, esum(last, pl, mo, cst)});
  endtask
  // -------------
  // main sequence
  // -------------
  initial begin
    logic [31:0] q;
    rows = '{'{7'h20, 14'h3F3F, 11'h417, 32'h0007_0008},
      '{7'h22, 14'h2AE6, 11'h51E, 32'h8007_0004}, '{7'h00, 14'h1FF5, 11'h21B, 32'h0007_0008},
      '{7'h02, 14'h0000, 11'h30C, 32'h8007_0000}, '{7'h20, 14'h3FFD, 11'h617, 32'h0007_0008},
      '{7'h20, 14'h3FFC, 11'h117, 32'h0007_0008}, '{7'h00, 14'h3FFF, 11'h017, 32'h0007_0008},
      '{7'h08, 14'h0000, 11'h30C, 32'h8007_0000},
      '{7'h0A, 14'h004F, 11'h03C, 32'h8007_0000}, '{7'h08, 14'h002A, 11'h106, 32'h8FFF_0000},
      '{7'h38, 14'h001D, 11'h215, 32'h8EFF_0000}};
    rv = '{36'h2_0000_07FF, 36'h3_0000_0800, 36'h4_0000_3F7F, 36'h5_0000_0000,
      36'h6_0000_0000, 36'h7_0000_3FFF, 36'h1_0000_0000, 36'h0_0000_0000,
      36'hA_0000_0000, 36'hF_0000_0000};
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i].ctrl, rows[i].cfg, 14'h0007, 14'h0800, 32'h3F7F, 16'h0, 1'b0);
      av(1, 4'h7, 0, q);
      chk(q, {18'h0, vw()});
      av(1, 4'h8, 0, q);
      chk({21'h0, q[10:0]}, {21'h0, rows[i].dec});
      av(1, 4'h9, 0, q);
      chk(q, rows[i].rng);
      $display("row %0d done", i);
    end
    // folded upper part, legacy constant with wrap, slow device, write while busy
    slow <= 1'b1;
    run(7'h04, 14'h3FFF, 14'h0007, 14'h0004, 32'h0060_001F, 16'hF3E0, 1'b1);
    av(1, 4'h2, 0, q);
    chk(q, 32'h0000_0007);
    $display("fold test done");
    // fully and three-quarter protected
    run(7'h02, 14'h0000, 14'h0007, 14'h0000, 32'h3F7F, 16'h0, 1'b0);
    run(7'h02, 14'h0000, 14'h0007, 14'h0002, 32'h3F7F, 16'h0, 1'b0);
    // automatic boundary; follows a three-quarter protected run so a stale word would show
    run(7'h40, 14'h151F, 14'h0007, 14'h0002, 32'h3F7F, 16'h0, 1'b0);
    av(0, 4'h3, 32'h0000_0800, q);
    av(1, 4'h3, 0, q);
    chk(q, 32'h0000_0002);
    av(1, 4'h9, 0, q);
    chk(q, 32'h8007_0002);
    $display("protect test done");
    // reset in mid run, then reset values and an unmapped index
    av(0, 4'h0, 32'h1, q);
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (rv[i]) begin
      av(1, rv[i][35:32], 0, q);
      chk(q, rv[i][31:0]);
    end
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire

/* File: bench/cwc_dev_model.sv */
// behavioural device: program memory, ids and configuration word
`timescale 1ns/1ps
`default_nettype none
module cwc_dev_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic mem_req_in,
  input wire logic [13:0] mem_addr_in,
  input wire logic [13:0] cfg_word_in,
  input wire logic layout_b_in,
  input wire logic small_in,
  input wire logic slow_in,
  output logic mem_ack_out,
  output logic [13:0] mem_data_out
);
  logic [2:0] dly_q;
  logic [13:0] word;
  // ------------
  // read-out map
  // ------------
  // config and ids answer whatever the protection
  always_comb begin
    case (mem_addr_in)
      14'h2007: word = cfg_word_in | (layout_b_in ? 14'h3F80 : 14'h00C0);
      14'h2000: word = 14'h0012;
      14'h2001: word = 14'h0037;
      14'h2002: word = 14'h0004;
      14'h2003: word = 14'h0026;
      default: word = (mem_addr_in & (small_in ? 14'h0FFF : 14'h3FFF)) ^ 14'h25E6;
    endcase
  end
  // ---------
  // handshake
  // ---------
  // released data inverts so a stale capture shows
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out <= 1'b0;
      mem_data_out <= 14'h0000;
      dly_q <= 3'h0;
    end else if (mem_req_in && !mem_ack_out) begin
      dly_q <= dly_q + 3'h1;
      if (dly_q >= (slow_in ? 3'h5 : 3'h0)) begin
        mem_ack_out <= 1'b1;
        mem_data_out <= word;
        dly_q <= 3'h0;
      end
    end else if (!mem_req_in && mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_data_out <= ~mem_data_out;
    end
  end
endmodule
`default_nettype wire

/* File: bench/cwc_top_sva.sv */
// checker: bus and device read port timing
`timescale 1ns/1ps
`default_nettype none
module cwc_top_sva (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic mem_req_out,
  input wire logic [13:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [13:0] mem_data_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // --------
  // bus side
  // --------
  a_read_wait: assert property (
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read not answered after one wait cycle");
  a_write_nowait: assert property (
    avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
  a_idle_nowait: assert property (
    !avs_read_in |-> !avs_waitrequest_out) else $error("stall with no request");
  a_data_hold: assert property (
    $changed(avs_readdata_out) |-> $past(avs_read_in) && $past(avs_waitrequest_out))
    else $error("read data moved outside a read");
  // -----------
  // device side
  // -----------
  a_addr_hold: assert property (
    mem_req_out && $past(mem_req_out) |-> $stable(mem_addr_out))
    else $error("address moved during request");
  a_req_hold: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out) else $error("request dropped early");
  a_req_drop: assert property (
    $rose(mem_ack_in) |-> ##[1:4] !mem_req_out) else $error("request not released");
  a_no_reissue: assert property (
    mem_ack_in && !mem_req_out |=> !mem_req_out) else $error("request before ack fell");
  a_req_gap: assert property (
    $fell(mem_ack_in) |-> !mem_req_out [*2]) else $error("request gap too short");
endmodule
bind cwc_top cwc_top_sva u_sva (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .mem_req_out(mem_req_out),
  .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in)
);
`default_nettype wire

/* File: verilog/cwc_acc_if.sv */
// accumulator link between the sequencer and the sum engine
`timescale 1ns/1ps
`default_nettype none
interface cwc_acc_if;
  logic clear;
  logic add;
  logic last;
  logic [15:0] term;
  logic [15:0] sum;
  logic done;
  modport seq (output clear, output add, output last, output term, input sum, input done);
  modport eng (input clear, input add, input last, input term, output sum, output done);
endinterface
`default_nettype wire

/* File: verilog/cwc_pkg.sv */
// constants for the configuration word decoder and checksum controller
package cwc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_LAST = 4'h2;
  localparam logic [3:0] REG_PLAIN = 4'h3;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_CONST = 4'h5;
  localparam logic [3:0] REG_RESULT = 4'h6;
  localparam logic [3:0] REG_CFG = 4'h7;
  localparam logic [3:0] REG_DECODE = 4'h8;
  localparam logic [3:0] REG_RANGE = 4'h9;
  localparam logic [3:0] REG_ID = 4'hA;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_ID_EN = 1;
  localparam int CTRL_FOLD = 2;
  localparam int CTRL_LAYOUT_B = 3;
  localparam int CTRL_SMALL = 4;
  localparam int CTRL_PLL = 5;
  localparam int CTRL_AUTO = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int MASK_OR_LO = 16;
  localparam int DEC_UNIFORM = 2;
  localparam int DEC_POWERUP_DELAY_TIMER = 3;
  localparam int DEC_WDT = 4;
  localparam int DEC_BOR = 5;
  localparam int DEC_OSC_LO = 8;
  localparam int RANGE_HI_LO = 16;
  localparam int RANGE_ANY = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] LAST_RST = 14'h07FF;
  localparam logic [13:0] PLAIN_RST = 14'h0800;
  localparam logic [13:0] MASK_RST = 14'h3F7F;
  localparam logic [13:0] OR_RST = 14'h0000;
  localparam logic [15:0] CONST_RST = 16'h0000;

  // ----------------------------------------------------------------
  // device side map and configuration word layout
  // ----------------------------------------------------------------
  localparam logic [13:0] ID_BASE = 14'h2000;
  localparam logic [13:0] CFG_ADDR = 14'h2007;
  localparam logic [13:0] ALIAS_MASK = 14'h0FFF;
  localparam logic [1:0] ID_LAST = 2'h3;
  localparam int CFG_BOR = 6;
  localparam int CFG_POWERUP_DELAY_TIMER_OFF = 3;
  localparam int CFG_WDT = 2;
  localparam int CP_B_LO = 4;
  localparam logic [13:0] UNIMP_A = 14'h00C0;
  localparam logic [13:0] UNIMP_B = 14'h3F80;
  localparam logic [1:0] CP_NONE = 2'b11;
  localparam logic [1:0] CP_HALF = 2'b10;
  localparam logic [1:0] CP_3Q = 2'b01;
  localparam logic [13:0] B_BIG_HALF_HI = 14'h0FFF;
  localparam logic [13:0] B_BIG_3Q_HI = 14'h1EFF;
  localparam logic [13:0] B_SMALL_HALF_HI = 14'h07FF;
  localparam logic [13:0] B_SMALL_3Q_HI = 14'h0EFF;

  // oscillator kinds as reported in the decode register
  localparam logic [2:0] OSC_RC = 3'h0;
  localparam logic [2:0] OSC_HS = 3'h1;
  localparam logic [2:0] OSC_XT = 3'h2;
  localparam logic [2:0] OSC_LP = 3'h3;
  localparam logic [2:0] OSC_EXT_PLL = 3'h4;
  localparam logic [2:0] OSC_HS_PLL = 3'h5;
  localparam logic [2:0] OSC_EXT_CLOCK_OUTPUT_PIN = 3'h6;
endpackage

/* File: verilog/cwc_sum_engine.sv */
// 16-bit wrapping accumulator, one term per clock
`timescale 1ns/1ps
`default_nettype none
module cwc_sum_engine (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  cwc_acc_if.eng acc
);
  logic [15:0] sum_q;
  logic done_q;

  // ----------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------
  // carries past bit 15 fall off the top
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sum_q <= 16'h0000;
    end else if (acc.clear) begin
      sum_q <= 16'h0000;
    end else if (acc.add) begin
      sum_q <= sum_q + acc.term;
    end
  end

  // done rises on the same edge the final term lands
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
    end else if (acc.clear) begin
      done_q <= 1'b0;
    end else if (acc.add && acc.last) begin
      done_q <= 1'b1;
    end
  end

  assign acc.sum = sum_q;
  assign acc.done = done_q;
endmodule
`default_nettype wire

/* File: verilog/cwc_top.sv */
// checksum controller: reads the device, decodes its configuration word
`timescale 1ns/1ps
`default_nettype none
module cwc_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic mem_req_out,
  output logic [13:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [13:0] mem_data_in
);
  typedef enum logic [5:0] {
    CWC_IDLE = 6'b000001,
    CWC_REQ = 6'b000010,
    CWC_REL = 6'b000100,
    CWC_CFG = 6'b001000,
    CWC_ID = 6'b010000,
    CWC_CONST = 6'b100000
  } cwc_state_e;

  typedef enum logic [2:0] {
    STG_ID = 3'b001,
    STG_CFG = 3'b010,
    STG_MEM = 3'b100
  } cwc_stage_e;

  cwc_state_e state_q;
  cwc_stage_e stage_q;
  logic [6:0] ctrl_q;
  logic [13:0] last_q, plain_q, mask_q, or_q;
  logic [15:0] const_q, result_q;
  logic done_q;
  logic [13:0] cfg_q, addr_q, word_q;
  logic [3:0] id_q [4];
  logic [1:0] idx_q;
  logic ack_s1_q, ack_s2_q;
  logic [13:0] data_s1_q, data_s2_q;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  cwc_acc_if acc ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // fold upper seven bits onto lower seven with xnor
  function automatic logic [15:0] fold_word(input logic [13:0] w);
    fold_word = {9'h0, ~(w[13:7] ^ w[6:0])};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // data is stable while ack is high, so two flops per bit suffice
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      data_s1_q <= 14'h0000;
      data_s2_q <= 14'h0000;
    end else begin
      ack_s1_q <= mem_ack_in;
      ack_s2_q <= ack_s1_q;
      data_s1_q <= mem_data_in;
      data_s2_q <= data_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic layout_b, small_dev, pll_dev;
  logic [13:0] cfg_view;
  logic [1:0] cp_code;
  logic cp_uniform, bor_on, powerup_delay_timer_on, wdt_on;
  logic [2:0] osc_kind;
  logic [13:0] size_w, prot_lo, prot_hi, auto_end, plain_end;
  logic prot_any;

  assign layout_b = ctrl_q[cwc_pkg::CTRL_LAYOUT_B];
  assign small_dev = ctrl_q[cwc_pkg::CTRL_SMALL];
  assign pll_dev = ctrl_q[cwc_pkg::CTRL_PLL];
  // missing positions always read as ones
  assign cfg_view = cfg_q | (layout_b ? cwc_pkg::UNIMP_B : cwc_pkg::UNIMP_A);
  assign cp_code = cfg_view[cwc_pkg::CP_B_LO +: 2];
  // layout A repeats the pair; a mismatch leaves the scheme undefined
  assign cp_uniform = layout_b ||
    ((cfg_view[13:12] == cp_code) && (cfg_view[11:10] == cp_code) &&
     (cfg_view[9:8] == cp_code));
  assign bor_on = layout_b && cfg_view[cwc_pkg::CFG_BOR];
  assign powerup_delay_timer_on = !cfg_view[cwc_pkg::CFG_POWERUP_DELAY_TIMER_OFF] || bor_on;
  assign wdt_on = cfg_view[cwc_pkg::CFG_WDT];
  assign size_w = last_q + 14'h0001;

  // oscillator meaning depends on part family
  always_comb begin
    if (pll_dev && !layout_b) begin
      case (cfg_view[1:0])
        2'b11: osc_kind = cwc_pkg::OSC_EXT_PLL;
        2'b10: osc_kind = cwc_pkg::OSC_HS_PLL;
        2'b01: osc_kind = cwc_pkg::OSC_EXT_CLOCK_OUTPUT_PIN;
        default: osc_kind = cwc_pkg::OSC_HS;
      endcase
    end else begin
      case (cfg_view[1:0])
        2'b11: osc_kind = cwc_pkg::OSC_RC;
        2'b10: osc_kind = cwc_pkg::OSC_HS;
        2'b01: osc_kind = cwc_pkg::OSC_XT;
        default: osc_kind = cwc_pkg::OSC_LP;
      endcase
    end
  end

  // protected address range: layout A guards the top, layout B the bottom
  always_comb begin
    prot_any = (cp_code != cwc_pkg::CP_NONE);
    prot_lo = 14'h0000;
    prot_hi = last_q;
    auto_end = size_w;
    if (!layout_b) begin
      case (cp_code)
        cwc_pkg::CP_NONE: auto_end = size_w;
        cwc_pkg::CP_HALF: auto_end = {1'b0, size_w[13:1]};
        cwc_pkg::CP_3Q: auto_end = {2'b00, size_w[13:2]};
        default: auto_end = 14'h0000;
      endcase
      prot_lo = auto_end;
    end else if (small_dev) begin
      case (cp_code)
        cwc_pkg::CP_HALF: prot_hi = cwc_pkg::B_SMALL_HALF_HI;
        cwc_pkg::CP_3Q: prot_hi = cwc_pkg::B_SMALL_3Q_HI;
        default: prot_hi = last_q;
      endcase
    end else begin
      case (cp_code)
        cwc_pkg::CP_HALF: prot_hi = cwc_pkg::B_BIG_HALF_HI;
        cwc_pkg::CP_3Q: prot_hi = cwc_pkg::B_BIG_3Q_HI;
        default: prot_hi = last_q;
      endcase
    end
  end

  // auto boundary only meaningful for layout A, else software sets it
  assign plain_end = (ctrl_q[cwc_pkg::CTRL_AUTO] && !layout_b) ? auto_end : plain_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic start_req, in_plain, fold_on, next_read, addr_end;
  logic [15:0] packed_id;

  assign start_req = avs_write_in && (avs_address_in == cwc_pkg::REG_CTRL) &&
    avs_writedata_in[cwc_pkg::CTRL_START];
  assign fold_on = ctrl_q[cwc_pkg::CTRL_FOLD];
  assign in_plain = (addr_q < plain_end);
  assign packed_id = {id_q[0], id_q[1], id_q[2], id_q[3]};
  // stop reading once nothing past the plain region contributes
  assign addr_end = (addr_q == last_q);
  assign next_read = !addr_end && (fold_on || ((addr_q + 14'h0001) < plain_end));

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CWC_IDLE;
      stage_q <= STG_ID;
      addr_q <= 14'h0000;
      idx_q <= 2'h0;
      word_q <= 14'h0000;
    end else begin
      case (state_q)
        CWC_IDLE: begin
          if (start_req) begin
            state_q <= CWC_REQ;
            stage_q <= STG_ID;
            addr_q <= cwc_pkg::ID_BASE;
            idx_q <= 2'h0;
          end
        end
        CWC_REQ: begin
          if (ack_s2_q) begin
            word_q <= data_s2_q;
            state_q <= CWC_REL;
          end
        end
        CWC_REL: begin
          if (!ack_s2_q) begin
            state_q <= CWC_REQ;
            case (stage_q)
              STG_ID: begin
                idx_q <= idx_q + 2'h1;
                addr_q <= addr_q + 14'h0001;
                if (idx_q == cwc_pkg::ID_LAST) begin
                  stage_q <= STG_CFG;
                  addr_q <= cwc_pkg::CFG_ADDR;
                end
              end
              STG_CFG: begin
                stage_q <= STG_MEM;
                addr_q <= 14'h0000;
                if (!fold_on && (plain_end == 14'h0000)) begin
                  state_q <= CWC_CFG;
                end
              end
              default: begin
                addr_q <= addr_q + 14'h0001;
                if (!next_read) begin
                  state_q <= CWC_CFG;
                end
              end
            endcase
          end
        end
        CWC_CFG: state_q <= CWC_ID;
        CWC_ID: state_q <= CWC_CONST;
        CWC_CONST: state_q <= CWC_IDLE;
        default: state_q <= CWC_IDLE;
      endcase
    end
  end

  // ids captured on release, configuration word as it arrives
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= 14'h3FFF;
      for (int i = 0; i < 4; i++) begin
        id_q[i] <= 4'h0;
      end
    end else begin
      if (state_q == CWC_REL && !ack_s2_q && stage_q == STG_ID) begin
        id_q[idx_q] <= word_q[3:0];
      end
      // taken on arrival so the memory skip decision already sees this word
      if (state_q == CWC_REQ && ack_s2_q && stage_q == STG_CFG) begin
        cfg_q <= data_s2_q;
      end
    end
  end

  // term selection; protected words fold or drop out
  always_comb begin
    acc.clear = (state_q == CWC_IDLE) && start_req;
    acc.add = 1'b0;
    acc.last = 1'b0;
    acc.term = 16'h0000;
    case (state_q)
      CWC_REL: begin
        if (!ack_s2_q && stage_q == STG_MEM) begin
          acc.add = in_plain || fold_on;
          acc.term = in_plain ? {2'b00, word_q} : fold_word(word_q);
        end
      end
      CWC_CFG: begin
        acc.add = 1'b1;
        acc.term = {2'b00, (cfg_view & mask_q) | or_q};
      end
      CWC_ID: begin
        acc.add = ctrl_q[cwc_pkg::CTRL_ID_EN];
        acc.term = packed_id;
      end
      CWC_CONST: begin
        acc.add = 1'b1;
        acc.last = 1'b1;
        acc.term = const_q;
      end
      default: acc.add = 1'b0;
    endcase
  end

  cwc_sum_engine u_engine (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .acc(acc)
  );

  // four-phase handshake; alias wraps upper half for the small layout B part
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_req_out <= 1'b0;
      mem_addr_out <= 14'h0000;
    end else begin
      mem_req_out <= (state_q == CWC_REQ) && !ack_s2_q;
      if (stage_q == STG_MEM && layout_b && small_dev) begin
        mem_addr_out <= addr_q & cwc_pkg::ALIAS_MASK;
      end else begin
        mem_addr_out <= addr_q;
      end
    end
  end

  // result latched the cycle after the last term
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      result_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (acc.clear) begin
      done_q <= 1'b0;
    end else if (acc.done && !done_q) begin
      result_q <= acc.sum;
      done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  // setup writes are ignored while a run is in progress
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 7'h00;
      last_q <= cwc_pkg::LAST_RST;
      plain_q <= cwc_pkg::PLAIN_RST;
      mask_q <= cwc_pkg::MASK_RST;
      or_q <= cwc_pkg::OR_RST;
      const_q <= cwc_pkg::CONST_RST;
    end else if (avs_write_in && state_q == CWC_IDLE) begin
      case (avs_address_in)
        cwc_pkg::REG_CTRL: ctrl_q <= {avs_writedata_in[6:1], 1'b0};
        cwc_pkg::REG_LAST: last_q <= avs_writedata_in[13:0];
        cwc_pkg::REG_PLAIN: plain_q <= avs_writedata_in[13:0];
        cwc_pkg::REG_MASK: begin
          mask_q <= avs_writedata_in[13:0];
          or_q <= avs_writedata_in[cwc_pkg::MASK_OR_LO +: 14];
        end
        cwc_pkg::REG_CONST: const_q <= avs_writedata_in[15:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // read mux; unmapped indices read zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (avs_address_in)
      cwc_pkg::REG_CTRL: rmux = {25'h0, ctrl_q};
      cwc_pkg::REG_STATUS: rmux = {30'h0, done_q, state_q != CWC_IDLE};
      cwc_pkg::REG_LAST: rmux = {18'h0, last_q};
      cwc_pkg::REG_PLAIN: rmux = {18'h0, plain_end};
      cwc_pkg::REG_MASK: rmux = {2'b00, or_q, 2'b00, mask_q};
      cwc_pkg::REG_CONST: rmux = {16'h0000, const_q};
      cwc_pkg::REG_RESULT: rmux = {16'h0000, result_q};
      cwc_pkg::REG_CFG: rmux = {18'h0, cfg_view};
      cwc_pkg::REG_DECODE: begin
        rmux[1:0] = cp_code;
        rmux[cwc_pkg::DEC_UNIFORM] = cp_uniform;
        rmux[cwc_pkg::DEC_POWERUP_DELAY_TIMER] = powerup_delay_timer_on;
        rmux[cwc_pkg::DEC_WDT] = wdt_on;
        rmux[cwc_pkg::DEC_BOR] = bor_on;
        rmux[cwc_pkg::DEC_OSC_LO +: 3] = osc_kind;
      end
      cwc_pkg::REG_RANGE: begin
        rmux[13:0] = prot_lo;
        rmux[cwc_pkg::RANGE_HI_LO +: 14] = prot_hi;
        rmux[cwc_pkg::RANGE_ANY] = prot_any;
      end
      cwc_pkg::REG_ID: rmux = {16'h0000, packed_id};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // one wait state on reads so the data comes from a flop
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_ack_q <= avs_read_in && !rd_ack_q;
      if (avs_read_in && !rd_ack_q) begin
        rdata_q <= rmux;
      end
    end
  end

  assign avs_waitrequest_out = avs_read_in && !rd_ack_q;
  assign avs_readdata_out = rdata_q;
endmodule
`default_nettype wire
